// *** src/pwc_pkg.sv ***
/*
 * Shared constants, types and register layout of the PHY mode and wake control block.
 * Assumes a single 10 MHz clock and synchronous inputs from the PHY analog and bus side.
 */
package pwc_pkg;
	// Clock and documented times
	localparam longint unsigned CLK_HZ = 64'd10000000;
	localparam longint unsigned BREAK_LINK_MS = 64'd1200;
	localparam longint unsigned PMT_RST_US = 64'd100;
	localparam longint unsigned BCR_RST_US = 64'd256;
	localparam longint unsigned BREAK_LINK_CYC = (BREAK_LINK_MS * CLK_HZ + 64'd999) / 64'd1000;
	localparam longint unsigned PMT_RST_CYC = (PMT_RST_US * CLK_HZ + 64'd999999) / 64'd1000000;
	localparam longint unsigned BCR_RST_CYC = (BCR_RST_US * CLK_HZ + 64'd999999) / 64'd1000000;
	localparam int TMR_W = 24;
	localparam int TMR_N = 3;
	localparam int TMR_BREAK = 0;
	localparam int TMR_PMT = 1;
	localparam int TMR_BCR = 2;

	// Management register offsets
	localparam logic [4:0] OFS_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] OFS_MODE_CONTROL = 5'h11;
	localparam logic [4:0] OFS_CROSSOVER = 5'h1b;
	// Configuration space offsets
	localparam logic [7:0] OFS_PM_CAP = 8'h78;
	localparam logic [7:0] OFS_PM_CSR = 8'h7c;

	// Basic control fields
	localparam int BCR_SOFT_RESET = 15;
	localparam int BCR_SPEED = 13;
	localparam int BCR_AN_ENABLE = 12;
	localparam int BCR_POWER_DOWN = 11;
	localparam int BCR_AN_RESTART = 9;
	localparam int BCR_DUPLEX = 8;
	localparam logic [15:0] BCR_RST = 16'h3000;
	// Mode control fields
	localparam int MCS_EON_FLAG = 15;
	localparam int MCS_EON_IE = 14;
	localparam int MCS_EDPD_EN = 13;
	localparam int MCS_ENERGY = 1;
	localparam logic [15:0] MCS_RST = 16'h0000;
	// Crossover fields
	localparam int XO_AUTO_DIS = 15;
	localparam int XO_SWAP = 13;
	localparam logic [15:0] XO_RST = 16'h0000;
	// Power management control
	localparam int PMT_PHY_SOFT_RESET_BIT = 10;

	// Capability word; identity-like fields are arbitrary neutral values
	localparam logic [7:0] PMC_CAP_ID = 8'h01;
	localparam logic [7:0] PMC_NEXT_PTR = 8'h00;
	localparam logic [2:0] PMC_VERSION = 3'h2;
	localparam logic [2:0] PMC_AUX_CUR_AUX = 3'h1;
	localparam logic [2:0] PMC_AUX_CUR_NOAUX = 3'h0;
	localparam logic [3:0] PMC_PME_SUP_BASE = 4'h9;
	// Control and status fields
	localparam int CSR_PME_STATUS = 15;
	localparam int CSR_PME_EN = 8;
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D3 = 2'h3;

	typedef enum logic [1:0] {
		AN_DROP = 2'b00,
		AN_NEG = 2'b01,
		AN_UP = 2'b11,
		AN_FORCED = 2'b10
	} pwc_an_t;

	typedef struct packed {
		logic sel;
		logic we;
		logic [4:0] addr;
		logic [15:0] wdata;
	} pwc_mgmt_req_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pwc_cfg_req_t;

	typedef struct packed {
		logic bcr_spd;
		logic bcr_an;
		logic bcr_pd;
		logic bcr_dup;
		logic edpd_en;
		logic eon_ie;
		logic eon_flag;
		logic energy_d;
		logic mdix_dis;
		logic mdix_sel;
		logic strap_q;
		logic strap_done;
		pwc_an_t an;
		logic [1:0] pstate;
		logic pme_en;
		logic pme_st;
		logic res_spd;
		logic res_dup;
		logic pd_d;
		logic [15:0] mgmt_rdata;
		logic [31:0] cfg_rdata;
		logic cfg_ack;
	} pwc_state_t;
endpackage : pwc_pkg

// *** src/pwc_span_timer.sv ***
/*
 * One-shot interval counter for reset and link-drop intervals.
 * Assumes start is a single-cycle pulse and len is at least one.
 */
`timescale 1ns/1ps
module pwc_span_timer
	import pwc_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [TMR_W-1:0] len,
	output logic busy,
	output logic done
);
	logic [TMR_W-1:0] cnt_q;
	logic [TMR_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start) begin
			cnt_d = len;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign done = (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1});
endmodule : pwc_span_timer

// *** src/pwc_top.sv ***
/*
 * PHY mode control (negotiation, forced mode, duplex, crossover, power-down, soft resets)
 * and bus power management registers with the wake request output.
 * Assumes all inputs are synchronous to clock; analog PHY and bus logic sit outside.
 */
`timescale 1ns/1ps
// Behaviour
// - Setting the restart bit restarts negotiation at any time; here only when the same write also sets bit 12 and leaves bit 15 clear.
// - Loss of received signal restarts negotiation automatically.
// - Management restart halts traffic, waits the link-drop interval, then negotiates.
// - Negotiation off: speed and duplex come from control bits 13 and 8.
// - Negotiation on: forced speed and duplex bits are ignored.
// - Half duplex: carrier on transmit or receive; receive during transmit is collision.
// - Full duplex: carrier on receive only, collision never reported.
// - Automatic crossover follows detected pair roles.
// - Crossover disable bit or strap turns it off; select bit chooses pairs.
// - General power-down bit keeps the PHY off except management.
// - Clearing general power-down powers up and applies a PHY reset.
// - Energy-detect mode powers down and silences PHY while no line energy.
// - Energy arrival powers up, keeps prior state, sets energy-on flag.
// - Enabled energy-on event becomes PHY interrupt and wake event.
// - Power control bit 10 starts PHY reset, self-clears after about 100us.
// - Control bit 15 resets PHY except exempt bits, clears after about 256us.
// - Enabled wake events drive wake request low in every power state.
// - Capability register at 78h, control and status at 7Ch.
// - Data scale and select fields always read zero.
// - Aux current field depends on aux power detect input.
// - Wake from cold state only allowed when aux power detected.
// - Aux present without main power isolates the bus interface completely.
module pwc_top
	import pwc_pkg::*;
#(
	parameter logic [TMR_W-1:0] BREAK_CYCLES = TMR_W'(BREAK_LINK_CYC)
) (
	input wire logic clock,
	input wire logic arst_n,
	input pwc_pkg::pwc_mgmt_req_t mgmt_req,
	output logic [15:0] mgmt_rdata,
	input pwc_pkg::pwc_cfg_req_t cfg_req,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	input wire logic pmt_we,
	input wire logic [31:0] pmt_wdata,
	output logic [31:0] pmt_rdata,
	input wire logic signal_lost,
	input wire logic an_complete,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic pair_swap_detect,
	input wire logic crossover_auto_strap,
	input wire logic energy_present,
	input wire logic wake_frame,
	input wire logic link_change,
	input wire logic aux_power_detect,
	input wire logic main_power_good,
	input wire logic bus_reset_n,
	output logic speed_100,
	output logic full_duplex,
	output logic an_negotiating,
	output logic traffic_halt,
	output logic carrier_sense,
	output logic collision,
	output logic mdix_swap,
	output logic phy_powered_down,
	output logic phy_tx_enable,
	output logic phy_reset,
	output logic phy_irq,
	output logic wake_request_n,
	output logic bus_isolated
);
	import pwc_pkg::*;

	pwc_state_t q;
	pwc_state_t d;
	logic [TMR_N-1:0] tmr_start;
	logic [TMR_N-1:0] tmr_busy;
	logic [TMR_N-1:0] tmr_done;
	logic [TMR_W-1:0] tmr_len [TMR_N];
	logic bcr_wr, mcs_wr, xo_wr, mcs_rd, cfg_ok, csr_wr;
	logic mgmt_restart, pd_release, eon_event, pme_event, held, auto_xo;

	function automatic logic mgmt_hit(input pwc_mgmt_req_t r, input logic [4:0] ofs);
		mgmt_hit = r.sel && (r.addr == ofs);
	endfunction : mgmt_hit

	assign tmr_len[TMR_BREAK] = BREAK_CYCLES;
	assign tmr_len[TMR_PMT] = TMR_W'(PMT_RST_CYC);
	assign tmr_len[TMR_BCR] = TMR_W'(BCR_RST_CYC);

	genvar gi;
	generate
		for (gi = 0; gi < TMR_N; gi++) begin : g_tmr
			pwc_span_timer u_tmr (
				.clock(clock),
				.arst_n(arst_n),
				.start(tmr_start[gi]),
				.len(tmr_len[gi]),
				.busy(tmr_busy[gi]),
				.done(tmr_done[gi])
			);
		end
	endgenerate

	assign bcr_wr = mgmt_hit(mgmt_req, OFS_BASIC_CONTROL) && mgmt_req.we;
	assign mcs_wr = mgmt_hit(mgmt_req, OFS_MODE_CONTROL) && mgmt_req.we;
	assign xo_wr = mgmt_hit(mgmt_req, OFS_CROSSOVER) && mgmt_req.we;
	assign mcs_rd = mgmt_hit(mgmt_req, OFS_MODE_CONTROL) && !mgmt_req.we;
	assign bus_isolated = aux_power_detect && !main_power_good;
	assign cfg_ok = cfg_req.req && !bus_isolated;
	assign csr_wr = cfg_ok && cfg_req.we && (cfg_req.addr == OFS_PM_CSR);

	// Restart only counts when negotiation ends up enabled by the same write
	assign mgmt_restart = bcr_wr && mgmt_req.wdata[BCR_AN_RESTART]
		&& mgmt_req.wdata[BCR_AN_ENABLE] && !mgmt_req.wdata[BCR_SOFT_RESET];
	assign pd_release = q.pd_d && !q.bcr_pd;
	assign tmr_start[TMR_BREAK] = mgmt_restart;
	assign tmr_start[TMR_PMT] = pmt_we && pmt_wdata[PMT_PHY_SOFT_RESET_BIT] && !tmr_busy[TMR_PMT];
	assign tmr_start[TMR_BCR] = (bcr_wr && mgmt_req.wdata[BCR_SOFT_RESET] && !tmr_busy[TMR_BCR])
		|| pd_release;
	assign phy_reset = tmr_busy[TMR_PMT] || tmr_busy[TMR_BCR];

	assign phy_powered_down = q.bcr_pd || (q.edpd_en && !energy_present);
	assign held = phy_powered_down || phy_reset;
	assign traffic_halt = held || (q.an == AN_DROP);
	assign phy_tx_enable = !traffic_halt;
	assign an_negotiating = (q.an == AN_NEG);
	assign eon_event = q.edpd_en && energy_present && !q.energy_d;
	assign phy_irq = q.eon_flag && q.eon_ie;
	// Cold state wake needs aux power; with it absent the device is simply unpowered
	assign pme_event = (wake_frame || link_change || (eon_event && q.eon_ie))
		&& (main_power_good || aux_power_detect);
	assign wake_request_n = !(q.pme_st && q.pme_en);

	assign speed_100 = q.res_spd;
	assign full_duplex = q.res_dup;
	assign carrier_sense = q.res_dup ? rx_active : (rx_active || tx_active);
	assign collision = !q.res_dup && tx_active && rx_active;
	// Strap is taken one clock after release, so the reset value stands in meanwhile
	assign auto_xo = !q.mdix_dis && q.strap_q;
	assign mdix_swap = auto_xo ? pair_swap_detect : q.mdix_sel;

	assign mgmt_rdata = q.mgmt_rdata;
	assign cfg_ack = q.cfg_ack;
	assign cfg_rdata = q.cfg_rdata;
	assign pmt_rdata = {21'h0, tmr_busy[TMR_PMT], 10'h0};

	always_comb begin
		d = q;
		d.cfg_ack = 1'b0;
		d.energy_d = energy_present;
		d.pd_d = q.bcr_pd;
		if (!q.strap_done) begin
			d.strap_q = crossover_auto_strap;
			d.strap_done = 1'b1;
		end
		// Management writes
		if (bcr_wr) begin
			d.bcr_spd = mgmt_req.wdata[BCR_SPEED];
			d.bcr_an = mgmt_req.wdata[BCR_AN_ENABLE];
			d.bcr_pd = mgmt_req.wdata[BCR_POWER_DOWN];
			d.bcr_dup = mgmt_req.wdata[BCR_DUPLEX];
		end
		if (mcs_wr) begin
			d.edpd_en = mgmt_req.wdata[MCS_EDPD_EN];
			d.eon_ie = mgmt_req.wdata[MCS_EON_IE];
		end
		if (xo_wr) begin
			d.mdix_dis = mgmt_req.wdata[XO_AUTO_DIS];
			d.mdix_sel = mgmt_req.wdata[XO_SWAP];
		end
		// Soft resets restore defaults; control bit 15 exempts crossover and energy-detect enable, power control bit 10 resets all
		if (tmr_start[TMR_BCR] && !pd_release) begin
			d.bcr_spd = BCR_RST[BCR_SPEED];
			d.bcr_an = BCR_RST[BCR_AN_ENABLE];
			d.bcr_pd = BCR_RST[BCR_POWER_DOWN];
			d.bcr_dup = BCR_RST[BCR_DUPLEX];
			d.eon_ie = MCS_RST[MCS_EON_IE];
		end
		if (tmr_start[TMR_PMT]) begin
			d.bcr_spd = BCR_RST[BCR_SPEED];
			d.bcr_an = BCR_RST[BCR_AN_ENABLE];
			d.bcr_pd = BCR_RST[BCR_POWER_DOWN];
			d.bcr_dup = BCR_RST[BCR_DUPLEX];
			d.edpd_en = MCS_RST[MCS_EDPD_EN];
			d.eon_ie = MCS_RST[MCS_EON_IE];
			d.mdix_dis = XO_RST[XO_AUTO_DIS];
			d.mdix_sel = XO_RST[XO_SWAP];
		end
		// Energy-on flag clears on read; a new event in that cycle wins
		if (mcs_rd) begin
			d.eon_flag = 1'b0;
		end
		if (eon_event) begin
			d.eon_flag = 1'b1;
		end
		// Negotiation sequencer
		case (q.an)
			AN_FORCED: if (d.bcr_an) d.an = AN_NEG;
			AN_DROP: if (tmr_done[TMR_BREAK]) d.an = AN_NEG;
			AN_NEG: if (an_complete) d.an = AN_UP;
			AN_UP: if (signal_lost) d.an = AN_NEG;
			default: d.an = AN_NEG;
		endcase
		if (!d.bcr_an) begin
			d.an = AN_FORCED;
		end else if (mgmt_restart) begin
			d.an = AN_DROP;
		end else if (held && q.an != AN_DROP) begin
			d.an = AN_NEG;
		end
		if (d.bcr_an) begin
			if (q.an == AN_UP) begin
				d.res_spd = an_speed_100;
				d.res_dup = an_full_duplex;
			end
		end else begin
			d.res_spd = d.bcr_spd;
			d.res_dup = d.bcr_dup;
		end
		// Management read data, registered
		if (mgmt_req.sel && !mgmt_req.we) begin
			d.mgmt_rdata = '0;
			case (mgmt_req.addr)
				OFS_BASIC_CONTROL: begin
					d.mgmt_rdata[BCR_SOFT_RESET] = tmr_busy[TMR_BCR];
					d.mgmt_rdata[BCR_SPEED] = q.bcr_spd;
					d.mgmt_rdata[BCR_AN_ENABLE] = q.bcr_an;
					d.mgmt_rdata[BCR_POWER_DOWN] = q.bcr_pd;
					d.mgmt_rdata[BCR_DUPLEX] = q.bcr_dup;
				end
				OFS_MODE_CONTROL: begin
					d.mgmt_rdata[MCS_EON_FLAG] = q.eon_flag;
					d.mgmt_rdata[MCS_EON_IE] = q.eon_ie;
					d.mgmt_rdata[MCS_EDPD_EN] = q.edpd_en;
					d.mgmt_rdata[MCS_ENERGY] = energy_present;
				end
				OFS_CROSSOVER: begin
					d.mgmt_rdata[XO_AUTO_DIS] = q.mdix_dis;
					d.mgmt_rdata[XO_SWAP] = q.mdix_sel;
				end
				default: d.mgmt_rdata = '0;
			endcase
		end
		// Configuration space
		if (cfg_ok) begin
			d.cfg_ack = 1'b1;
			if (!cfg_req.we) begin
				case (cfg_req.addr)
					OFS_PM_CAP: d.cfg_rdata = {aux_power_detect, PMC_PME_SUP_BASE, 2'b00,
						aux_power_detect ? PMC_AUX_CUR_AUX : PMC_AUX_CUR_NOAUX,
						3'b000, PMC_VERSION, PMC_NEXT_PTR, PMC_CAP_ID};
					OFS_PM_CSR: d.cfg_rdata = {16'h0, q.pme_st, 6'h00, q.pme_en,
						6'h00, q.pstate};
					default: d.cfg_rdata = '0;
				endcase
			end
		end
		if (csr_wr && cfg_req.be[0]
			&& (cfg_req.wdata[1:0] == PS_D0 || cfg_req.wdata[1:0] == PS_D3)) begin
			d.pstate = cfg_req.wdata[1:0];
		end
		if (csr_wr && cfg_req.be[1]) begin
			d.pme_en = cfg_req.wdata[CSR_PME_EN];
			if (cfg_req.wdata[CSR_PME_STATUS]) begin
				d.pme_st = 1'b0;
			end
		end
		if (pme_event) begin
			d.pme_st = 1'b1;
		end
		if (!bus_reset_n && !bus_isolated) begin
			d.pstate = PS_D0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{bcr_spd: BCR_RST[BCR_SPEED], bcr_an: BCR_RST[BCR_AN_ENABLE],
				bcr_pd: BCR_RST[BCR_POWER_DOWN], bcr_dup: BCR_RST[BCR_DUPLEX],
				edpd_en: MCS_RST[MCS_EDPD_EN], eon_ie: MCS_RST[MCS_EON_IE],
				mdix_dis: XO_RST[XO_AUTO_DIS], mdix_sel: XO_RST[XO_SWAP],
				strap_q: 1'b1, an: AN_NEG, pstate: PS_D0, default: '0};
		end else begin
			q <= d;
		end
	end

	pd_off_a: assert property (
		@(posedge clock) disable iff (!arst_n) q.bcr_pd |-> (phy_powered_down && !phy_tx_enable))
		else $error("PHY active during general power-down");
	edpd_off_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(q.edpd_en && !energy_present) |-> !phy_tx_enable)
		else $error("transmit enabled without line energy");
	fdx_col_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		full_duplex |-> (!collision && (carrier_sense == rx_active)))
		else $error("full duplex carrier or collision wrong");
	hdx_col_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(!full_duplex && tx_active && rx_active) |-> (collision && carrier_sense))
		else $error("half duplex collision missed");
	forced_mode_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(bcr_wr && !mgmt_req.wdata[BCR_AN_ENABLE] && !mgmt_req.wdata[BCR_SOFT_RESET])
		|=> (speed_100 == $past(mgmt_req.wdata[BCR_SPEED])) && (an_negotiating == 1'b0))
		else $error("forced speed not applied");
	restart_drop_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		mgmt_restart |=> (traffic_halt && q.an == AN_DROP) [*8])
		else $error("restart did not hold link down");
	pmt_busy_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		tmr_start[TMR_PMT] |=> (pmt_rdata[PMT_PHY_SOFT_RESET_BIT] && phy_reset) [*8] ##[1:1000]
		!pmt_rdata[PMT_PHY_SOFT_RESET_BIT])
		else $error("PHY reset bit timing wrong");
	bcr_busy_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(bcr_wr && mgmt_req.wdata[BCR_SOFT_RESET]) |=> phy_reset ##1 q.bcr_an)
		else $error("soft reset not started");
	xo_manual_a: assert property (
		@(posedge clock) disable iff (!arst_n) q.mdix_dis |-> (mdix_swap == q.mdix_sel))
		else $error("manual pair select ignored");
	iso_ignore_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(bus_isolated && cfg_req.req && !(cfg_ok)) |=> !cfg_ack)
		else $error("isolated bus access answered");
	csr_zero_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(cfg_ok && !cfg_req.we && cfg_req.addr == OFS_PM_CSR) |=> (cfg_rdata[14:9] == 6'h00))
		else $error("data scale or select not zero");
	wake_a: assert property (
		@(posedge clock) disable iff (!arst_n)
		(pme_event && q.pme_en && !csr_wr) |=> !wake_request_n)
		else $error("wake request not asserted");
	eon_flag_a: assert property (
		@(posedge clock) disable iff (!arst_n) eon_event |=> q.eon_flag)
		else $error("energy-on flag not set");

	an_up_c: cover property (@(posedge clock) disable iff (!arst_n) q.an == AN_UP);
	drop_done_c: cover property (@(posedge clock) disable iff (!arst_n) tmr_done[TMR_BREAK]);
	eon_c: cover property (@(posedge clock) disable iff (!arst_n) eon_event && q.eon_ie);
	wake_c: cover property (@(posedge clock) disable iff (!arst_n) $fell(wake_request_n));
endmodule : pwc_top

// *** verification/pwc_link_partner.sv ***
/*
 * Far-end negotiation model: answers a negotiating PHY after a short or long delay.
 * Assumes an_negotiating comes from the block under test on the same clock.
 */
`timescale 1ns/1ps
module pwc_link_partner (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic an_negotiating,
	input wire logic slow,
	output logic an_complete,
	output logic an_speed_100,
	output logic an_full_duplex
);
	logic [3:0] wait_q;
	// Level completion, dropped as soon as the PHY leaves negotiation
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wait_q <= 4'h0;
			an_complete <= 1'b0;
		end else if (!an_negotiating) begin
			wait_q <= 4'h0;
			an_complete <= 1'b0;
		end else begin
			wait_q <= (wait_q == 4'hf) ? wait_q : wait_q + 4'h1;
			an_complete <= an_complete | (wait_q == (slow ? 4'hc : 4'h2));
		end
	end
	// Both ends offer everything, so the best common mode is 100M full
	assign an_speed_100 = 1'b1;
	assign an_full_duplex = 1'b1;
endmodule : pwc_link_partner

// *** verification/test_pwc_top.sv ***
/*
 * Self-checking bench for the PHY mode and wake control block.
 * Assumes the block's package and the link partner model are compiled first.
 */
`timescale 1ns/1ps
module test_pwc_top;
	import pwc_pkg::*;
	localparam int BRK = 20;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	pwc_mgmt_req_t mgmt_req = '0;
	pwc_cfg_req_t cfg_req = '0;
	logic pmt_we = 1'b0;
	logic [31:0] pmt_wdata = 32'h0;
	logic signal_lost = 1'b0, tx_active = 1'b0, rx_active = 1'b0, pair_swap_detect = 1'b0;
	logic crossover_auto_strap = 1'b1, energy_present = 1'b0, wake_frame = 1'b0;
	logic link_change = 1'b0, aux_power_detect = 1'b0, main_power_good = 1'b1;
	logic bus_reset_n = 1'b1, slow = 1'b0;
	logic an_complete, an_speed_100, an_full_duplex, cfg_ack, speed_100, full_duplex;
	logic an_negotiating, traffic_halt, carrier_sense, collision, mdix_swap, phy_irq;
	logic phy_powered_down, phy_tx_enable, phy_reset, wake_request_n, bus_isolated;
	logic [15:0] mgmt_rdata;
	logic [31:0] cfg_rdata, pmt_rdata;
	logic [63:0] mgmt_q[$];
	logic [63:0] cfg_q[$];
	logic rd_seen = 1'b0;
	int fail_count = 0;
	int compares = 0;
	int seed;

	pwc_top #(.BREAK_CYCLES(TMR_W'(BRK))) u_pwc_top (.clock, .arst_n, .mgmt_req, .mgmt_rdata,
		.cfg_req, .cfg_ack, .cfg_rdata, .pmt_we, .pmt_wdata, .pmt_rdata, .signal_lost,
		.an_complete, .an_speed_100, .an_full_duplex, .tx_active, .rx_active,
		.pair_swap_detect, .crossover_auto_strap, .energy_present, .wake_frame, .link_change,
		.aux_power_detect, .main_power_good, .bus_reset_n, .speed_100, .full_duplex,
		.an_negotiating, .traffic_halt, .carrier_sense, .collision, .mdix_swap,
		.phy_powered_down, .phy_tx_enable, .phy_reset, .phy_irq, .wake_request_n,
		.bus_isolated);
	pwc_link_partner u_pwc_link_partner (.clock, .arst_n, .an_negotiating, .slow,
		.an_complete, .an_speed_100, .an_full_duplex);

	always #50 clock = ~clock;

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic finish_test;
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// Results without a note are mismatches too, so refused requests are covered
	task automatic take(ref logic [63:0] q[$], input logic [31:0] got, input string nm);
		logic [63:0] e;
		if (q.size() == 0) begin
			check({nm, "_unexpected"}, 32'h0, 32'h1);
		end else begin
			e = q.pop_front();
			check(nm, e[31:0] & e[63:32], got & e[63:32]);
		end
	endtask : take

	always @(posedge clock) rd_seen <= mgmt_req.sel && !mgmt_req.we;
	always @(negedge clock) begin
		if (rd_seen) take(mgmt_q, {16'h0, mgmt_rdata}, "mgmt_rdata");
		if (cfg_ack === 1'b1) take(cfg_q, cfg_rdata, "cfg_rdata");
	end

	task automatic mgmt(input logic we, input logic [4:0] a, input logic [15:0] d,
		input logic [15:0] m);
		@(posedge clock);
		#1;
		mgmt_req = '{sel: 1'b1, we: we, addr: a, wdata: d};
		if (!we) mgmt_q.push_back({16'h0, m, 16'h0, d});
		@(posedge clock);
		#1;
		mgmt_req.sel = 1'b0;
	endtask : mgmt

	task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic [31:0] m);
		@(posedge clock);
		#1;
		cfg_req = '{req: 1'b1, we: we, addr: a, be: be, wdata: d};
		// Writes are acknowledged too; their note carries an empty mask
		cfg_q.push_back({m, d});
		@(posedge clock);
		#1;
		cfg_req.req = 1'b0;
	endtask : cfg

	function automatic logic mon(input int w);
		case (w)
			0: return traffic_halt;
			1: return phy_reset;
			2: return pmt_rdata[PMT_PHY_SOFT_RESET_BIT];
			3: return an_negotiating;
			4: return phy_powered_down;
			default: return wake_request_n;
		endcase
	endfunction : mon

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	// Counts cycles a busy level stays high
	task automatic measure(input int w, input int exp, input string nm);
		int n;
		n = 0;
		while (mon(w) === 1'b1 && n < 5000) begin
			step(1);
			n++;
		end
		check(nm, 32'(exp), 32'(n));
	endtask : measure

	task automatic wait_for(input int w, input logic v, input int max, input string nm);
		int n;
		n = 0;
		while (mon(w) !== v && n < max) begin
			step(1);
			n++;
		end
		check(nm, {31'h0, v}, {31'h0, mon(w)});
	endtask : wait_for

	task automatic duplex_loop(input logic fd);
		for (int i = 0; i < 4; i++) begin
			step(1);
			{tx_active, rx_active} = 2'(i);
			#10;
			check("carrier_sense", fd ? rx_active : tx_active | rx_active, carrier_sense);
			check("collision", fd ? 1'b0 : tx_active & rx_active, collision);
		end
		{tx_active, rx_active} = 2'b00;
	endtask : duplex_loop

	task automatic forced(input logic [15:0] d, input logic spd, input logic dup);
		mgmt(1'b1, OFS_BASIC_CONTROL, d, 16'h0);
		step(2);
		check("speed_100", spd, speed_100);
		check("full_duplex", dup, full_duplex);
		duplex_loop(dup);
	endtask : forced

	task automatic pulse_wake(input logic frame);
		step(1);
		if (frame) wake_frame = 1'b1;
		else link_change = 1'b1;
		step(1);
		wake_frame = 1'b0;
		link_change = 1'b0;
	endtask : pulse_wake

	function automatic logic [31:0] pmc(input logic aux);
		return {aux, PMC_PME_SUP_BASE, 2'b00, aux ? PMC_AUX_CUR_AUX : PMC_AUX_CUR_NOAUX,
			3'h0, PMC_VERSION, PMC_NEXT_PTR, PMC_CAP_ID};
	endfunction : pmc

	initial begin
		#4000000;
		fail_count++;
		finish_test();
	end

	initial begin
		seed = 31;
		repeat (2) @(posedge clock);
		#1;
		arst_n = 1'b1;
		mgmt(1'b0, OFS_BASIC_CONTROL, BCR_RST, 16'hffff);
		mgmt(1'b0, OFS_MODE_CONTROL, MCS_RST, 16'hffff);
		mgmt(1'b0, OFS_CROSSOVER, XO_RST, 16'hffff);
		mgmt(1'b0, 5'h05, 16'h0, 16'hffff);
		// Negotiation on with forced bits cleared: the partner's mode must win
		mgmt(1'b1, OFS_BASIC_CONTROL, 16'h1200, 16'h0);
		check("phy_tx_enable", 32'h0, {31'h0, phy_tx_enable});
		measure(0, BRK, "halt_cycles");
		check("an_negotiating", 32'h1, {31'h0, an_negotiating});
		wait_for(3, 1'b0, 40, "an_up");
		// Resolved mode is latched one clock after the link comes up
		step(1);
		check("speed_100", 32'h1, {31'h0, speed_100});
		check("full_duplex", 32'h1, {31'h0, full_duplex});
		duplex_loop(1'b1);
		slow = 1'b1;
		step(1);
		signal_lost = 1'b1;
		step(1);
		signal_lost = 1'b0;
		wait_for(3, 1'b1, 3, "relink");
		wait_for(3, 1'b0, 40, "an_up");
		forced(16'h0100, 1'b0, 1'b1);
		forced(16'h2000, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			pair_swap_detect = 1'($random(seed));
			step(2);
			check("mdix_swap", {31'h0, pair_swap_detect}, {31'h0, mdix_swap});
		end
		pair_swap_detect = 1'b0;
		mgmt(1'b1, OFS_CROSSOVER, 16'ha000, 16'h0);
		step(2);
		check("mdix_manual", 32'h1, {31'h0, mdix_swap});
		mgmt(1'b1, OFS_BASIC_CONTROL, 16'h0800, 16'h0);
		wait_for(4, 1'b1, 4, "general_pd");
		mgmt(1'b1, OFS_BASIC_CONTROL, 16'h0000, 16'h0);
		// Release reset starts one clock after the bit reads back clear
		step(1);
		measure(1, int'(BCR_RST_CYC), "pd_reset_cycles");
		check("powered_up", 32'h0, {31'h0, phy_powered_down});
		mgmt(1'b1, OFS_MODE_CONTROL, 16'h6000, 16'h0);
		wait_for(4, 1'b1, 4, "energy_pd");
		check("tx_silent", 32'h0, {31'h0, phy_tx_enable});
		energy_present = 1'b1;
		wait_for(4, 1'b0, 4, "energy_up");
		// Flag is registered on the clock that sees the new energy
		step(1);
		check("phy_irq", 32'h1, {31'h0, phy_irq});
		mgmt(1'b0, OFS_MODE_CONTROL, 16'he002, 16'hffff);
		mgmt(1'b0, OFS_MODE_CONTROL, 16'h6002, 16'hffff);
		check("irq_cleared", 32'h0, {31'h0, phy_irq});
		mgmt(1'b1, OFS_BASIC_CONTROL, 16'h8000, 16'h0);
		measure(1, int'(BCR_RST_CYC), "bcr_reset_cycles");
		mgmt(1'b0, OFS_BASIC_CONTROL, BCR_RST, 16'hffff);
		mgmt(1'b0, OFS_CROSSOVER, 16'ha000, 16'hffff);
		step(1);
		pmt_we = 1'b1;
		pmt_wdata = 32'h0000_0400;
		step(1);
		pmt_we = 1'b0;
		check("pmt_rdata", 32'h0000_0400, pmt_rdata);
		measure(2, int'(PMT_RST_CYC), "pmt_reset_cycles");
		mgmt(1'b0, OFS_CROSSOVER, XO_RST, 16'hffff);
		cfg(1'b0, OFS_PM_CAP, 4'h0, pmc(1'b0), 32'hffffffff);
		// The energy-on event above already raised wake status
		cfg(1'b0, OFS_PM_CSR, 4'h0, 32'h0000_8000, 32'h0000ff03);
		cfg(1'b1, OFS_PM_CSR, 4'h3, 32'h0000_8103, 32'h0);
		cfg(1'b1, OFS_PM_CSR, 4'h1, 32'h0000_0002, 32'h0);
		cfg(1'b0, OFS_PM_CSR, 4'h0, 32'h0000_0103, 32'h0000ff03);
		pulse_wake(1'b0);
		wait_for(5, 1'b0, 4, "wake_on_link");
		cfg(1'b0, OFS_PM_CSR, 4'h0, 32'h0000_8103, 32'h0000ff03);
		cfg(1'b1, OFS_PM_CSR, 4'h3, 32'h0000_8100, 32'h0);
		wait_for(5, 1'b1, 4, "wake_released");
		cfg(1'b0, OFS_PM_CSR, 4'h0, 32'h0000_0100, 32'h0000ff03);
		main_power_good = 1'b0;
		pulse_wake(1'b1);
		step(3);
		check("no_cold_wake", 32'h1, {31'h0, wake_request_n});
		aux_power_detect = 1'b1;
		step(1);
		check("bus_isolated", 32'h1, {31'h0, bus_isolated});
		pulse_wake(1'b1);
		wait_for(5, 1'b0, 4, "cold_wake");
		cfg_req = '{req: 1'b1, we: 1'b0, addr: OFS_PM_CAP, be: 4'h0, wdata: 32'h0};
		step(1);
		cfg_req.req = 1'b0;
		step(3);
		main_power_good = 1'b1;
		cfg(1'b0, OFS_PM_CAP, 4'h0, pmc(1'b1), 32'hffffffff);
		// Bus reset returns the power state to D0 but keeps the sticky wake bits
		cfg(1'b1, OFS_PM_CSR, 4'h1, 32'h0000_0003, 32'h0);
		bus_reset_n = 1'b0;
		step(1);
		bus_reset_n = 1'b1;
		cfg(1'b0, OFS_PM_CSR, 4'h0, 32'h0000_8100, 32'h0000ff03);
		step(3);
		check("pending_notes", 32'h0, 32'(mgmt_q.size() + cfg_q.size()));
		finish_test();
	end
endmodule : test_pwc_top
